// ### rtl/crc_rate_regs.svh
`ifndef CRC_RATE_REGS_SVH
`define CRC_RATE_REGS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define CRC_SETUP_IDX 6'h19
`define RATE_SETUP_IDX 6'h1a
`define MODE_SETUP_IDX 6'h20
`define IDX_HI 7
`define IDX_LO 2

// ------------------------------------------------------------
// transmit crc setup fields
// ------------------------------------------------------------
`define CRCS_PRESET_HI 31
`define CRCS_PRESET_LO 16
`define CRCS_SKIP_BIT 6
`define CRCS_SEL_HI 5
`define CRCS_SEL_LO 3
`define CRCS_WIDTH_BIT 2
`define CRCS_INV_BIT 1
`define CRCS_EN_BIT 0
`define CRCS_WMASK 32'hffff_007f
`define CRCS_RESET 32'h0000_0000

// ------------------------------------------------------------
// preset selector codes and start values
// ------------------------------------------------------------
`define SEL_ZERO 3'h0
`define SEL_6363 3'h1
`define SEL_A671 3'h2
`define SEL_FFFF 3'h3
`define SEL_0012 3'h4
`define SEL_E012 3'h5
`define SEL_CUSTOM 3'h7
`define PRESET_ZERO 16'h0000
`define PRESET_6363 16'h6363
`define PRESET_A671 16'ha671
`define PRESET_FFFF 16'hffff
`define PRESET_0012 16'h0012
`define PRESET_E012 16'he012
`define LOW_BYTE_MASK 16'h00ff
`define CRC5_MASK 16'h001f

// ------------------------------------------------------------
// receive rate setup fields and codes
// ------------------------------------------------------------
`define RATE_HI 2
`define RATE_LO 0
`define RATE_MSB 2
`define RATE_WMASK 32'h0000_0007
`define RATE_RESET 3'h0
`define RATE_106 3'h4
`define RATE_424 3'h6
`define RATE_848 3'h7

// ------------------------------------------------------------
// operating mode setup fields
// ------------------------------------------------------------
`define MODE_AUTO_BIT 0
`define MODE_READER_BIT 1
`define MODE_WMASK 32'h0000_0003
`define MODE_RESET 2'h0

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO_WORD 32'h0000_0000

`endif

// ### rtl/crc_rate_pkg.sv
package crc_rate_pkg;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

endpackage

// ### rtl/crc_preset_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_rate_regs.svh"

module crc_preset_decode
  import crc_rate_pkg::*;
(
  // selection
  input wire logic [2:0] sel_i,
  input wire logic [15:0] custom_i,
  input wire logic width5_i,
  // start value
  output logic [15:0] start_o
);

  logic [15:0] full_value;

  always_comb begin
    if (sel_i == `SEL_6363) begin
      full_value = `PRESET_6363;
    end else if (sel_i == `SEL_A671) begin
      full_value = `PRESET_A671;
    end else if (sel_i == `SEL_FFFF) begin
      full_value = `PRESET_FFFF;
    end else if (sel_i == `SEL_0012) begin
      full_value = `PRESET_0012;
    end else if (sel_i == `SEL_E012) begin
      full_value = `PRESET_E012;
    end else if (sel_i == `SEL_CUSTOM) begin
      full_value = custom_i;
    end else begin
      // zero code and the reserved code both start from zero
      full_value = `PRESET_ZERO;
    end
  end

  always_comb begin
    start_o = width5_i ? (full_value & `LOW_BYTE_MASK) : full_value;
  end

endmodule

`default_nettype wire

// ### rtl/tx_crc_and_rx_rate_config.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "crc_rate_regs.svh"

// How it works
// - A 16-bit software preset in bits 31:16 is the crc start value when the selector is 111b.
// - With the skip bit set, the first frame byte stays out of the crc, which starts at byte two.
// - The selector loads 0000h, 6363h, A671h, FFFFh, 0012h or E012h at frame start; 110b is spare.
// - In 5-bit crc operation only the low byte of the chosen preset is the start value.
// - Bit 2 picks a 16-bit crc when 0, the reset value, and a 5-bit crc when 1.
// - Bit 1 set sends the complement of the computed crc; clear, the reset value, sends it as is.
// - Bit 0 set makes the encoder compute and append a crc; it resets to 0.
// - The rate field reads 100 as 106 kBd, 110 as 424 kBd, 111 as 848 kBd; 000 to 011 and 101 are spare.
// - The rate field's top bit counts only in reader mode and is ignored in every other mode.
// - With auto detection on, a detected mode writes 100 for type A or B and 110 for 424 kBd.

module tx_crc_and_rx_rate_config
  import crc_rate_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // axi4-lite write address
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic [2:0] awprot_i,
  // axi4-lite write data
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // axi4-lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read address
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  input wire logic [2:0] arprot_i,
  // axi4-lite read data
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // transmit encoder
  input wire logic frame_start_i,
  input wire logic byte_done_i,
  input wire logic [15:0] crc_result_i,
  output logic crc_enable_o,
  output logic crc_width5_o,
  output logic crc_load_o,
  output logic [15:0] crc_start_value_o,
  output logic crc_accumulate_o,
  output logic [15:0] crc_tx_value_o,
  // mode detector
  input wire logic det_valid_i,
  input wire logic det_is_424_i,
  // receive signal processing
  output logic [2:0] rx_symbol_rate_o,
  output logic rx_rate_reserved_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb,
                                              input logic [31:0] wmask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_bytes = res & wmask;
  endfunction

  function automatic logic [5:0] word_index(input logic [7:0] addr);
    word_index = addr[`IDX_HI:`IDX_LO];
  endfunction

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == `CRC_SETUP_IDX) || (idx == `RATE_SETUP_IDX) ||
                (idx == `MODE_SETUP_IDX);
  endfunction

  function automatic logic rate_defined(input logic [2:0] code);
    rate_defined = (code == `RATE_106) || (code == `RATE_424) || (code == `RATE_848);
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  wr_state_t wr_state_reg, wr_state_next;
  rd_state_t rd_state_reg, rd_state_next;
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic commit;
  logic [5:0] commit_idx;
  logic [31:0] crc_setup_reg, crc_setup_next;
  logic [2:0] rate_reg, rate_next;
  logic [1:0] mode_reg, mode_next;
  logic [31:0] rate_merged;
  logic [31:0] mode_merged;
  logic [15:0] start_value;
  logic crc_load_reg, crc_load_next;
  logic [15:0] start_reg, start_next;
  logic accumulate_reg, accumulate_next;
  logic [15:0] tx_value_reg, tx_value_next;
  logic [2:0] rx_rate_reg, rx_rate_next;
  logic rx_reserved_reg, rx_reserved_next;
  logic [15:0] crc_masked;

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_got_next = aw_got_reg | (awvalid_i & awready_reg);
    w_got_next = w_got_reg | (wvalid_i & wready_reg);
    waddr_next = (awvalid_i & awready_reg) ? awaddr_i : waddr_reg;
    wdata_next = (wvalid_i & wready_reg) ? wdata_i : wdata_reg;
    wstrb_next = (wvalid_i & wready_reg) ? wstrb_i : wstrb_reg;
    awready_next = awready_reg;
    wready_next = wready_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    commit = 1'b0;
    commit_idx = word_index(waddr_next);
    case (wr_state_reg)
      WR_IDLE: begin
        if (aw_got_next && w_got_next) begin
          commit = 1'b1;
          wr_state_next = WR_RESP;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          awready_next = 1'b0;
          wready_next = 1'b0;
          bvalid_next = 1'b1;
          bresp_next = is_mapped(commit_idx) ? `RESP_OKAY : `RESP_SLVERR;
        end else begin
          awready_next = ~aw_got_next;
          wready_next = ~w_got_next;
        end
      end
      WR_RESP: begin
        if (bready_i) begin
          wr_state_next = WR_IDLE;
          bvalid_next = 1'b0;
          awready_next = 1'b1;
          wready_next = 1'b1;
        end
      end
      default: begin
        wr_state_next = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_state_reg <= WR_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= `ZERO_WORD;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always_comb begin
    rd_state_next = rd_state_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (arvalid_i && arready_reg) begin
          rd_state_next = RD_RESP;
          arready_next = 1'b0;
          rvalid_next = 1'b1;
          rresp_next = `RESP_OKAY;
          if (word_index(araddr_i) == `CRC_SETUP_IDX) begin
            rdata_next = crc_setup_reg;
          end else if (word_index(araddr_i) == `RATE_SETUP_IDX) begin
            rdata_next = {29'h0000_0000, rate_reg};
          end else if (word_index(araddr_i) == `MODE_SETUP_IDX) begin
            rdata_next = {30'h0000_0000, mode_reg};
          end else begin
            rdata_next = `ZERO_WORD;
            rresp_next = `RESP_SLVERR;
          end
        end
      end
      RD_RESP: begin
        if (rready_i) begin
          rd_state_next = RD_IDLE;
          arready_next = 1'b1;
          rvalid_next = 1'b0;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_state_reg <= RD_IDLE;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= `ZERO_WORD;
      rresp_reg <= `RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_comb begin
    crc_setup_next = crc_setup_reg;
    rate_next = rate_reg;
    mode_next = mode_reg;
    rate_merged = merge_bytes({29'h0000_0000, rate_reg}, wdata_next, wstrb_next, `RATE_WMASK);
    mode_merged = merge_bytes({30'h0000_0000, mode_reg}, wdata_next, wstrb_next, `MODE_WMASK);
    if (commit) begin
      if (commit_idx == `CRC_SETUP_IDX) begin
        crc_setup_next = merge_bytes(crc_setup_reg, wdata_next, wstrb_next,
                                     `CRCS_WMASK);
      end else if (commit_idx == `RATE_SETUP_IDX) begin
        rate_next = rate_merged[`RATE_HI:`RATE_LO];
      end else if (commit_idx == `MODE_SETUP_IDX) begin
        mode_next = mode_merged[`MODE_READER_BIT:`MODE_AUTO_BIT];
      end
    end
    // detector write lands after software so a same-cycle detection is kept
    if (det_valid_i && mode_reg[`MODE_AUTO_BIT]) begin
      rate_next = det_is_424_i ? `RATE_424 : `RATE_106;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crc_setup_reg <= `CRCS_RESET;
      rate_reg <= `RATE_RESET;
      mode_reg <= `MODE_RESET;
    end else begin
      crc_setup_reg <= crc_setup_next;
      rate_reg <= rate_next;
      mode_reg <= mode_next;
    end
  end

  // ------------------------------------------------------------
  // transmit encoder control
  // ------------------------------------------------------------
  crc_preset_decode u_preset (
    .sel_i(crc_setup_reg[`CRCS_SEL_HI:`CRCS_SEL_LO]),
    .custom_i(crc_setup_reg[`CRCS_PRESET_HI:`CRCS_PRESET_LO]),
    .width5_i(crc_setup_reg[`CRCS_WIDTH_BIT]),
    .start_o(start_value)
  );

  always_comb begin
    crc_load_next = 1'b0;
    start_next = start_reg;
    accumulate_next = accumulate_reg;
    // start value is frozen per frame so mid-frame writes cannot corrupt it
    if (frame_start_i) begin
      crc_load_next = crc_setup_reg[`CRCS_EN_BIT];
      start_next = start_value;
      accumulate_next = crc_setup_reg[`CRCS_EN_BIT] &
                        ~crc_setup_reg[`CRCS_SKIP_BIT];
    end else if (byte_done_i) begin
      accumulate_next = crc_setup_reg[`CRCS_EN_BIT];
    end
    crc_masked = crc_setup_reg[`CRCS_WIDTH_BIT] ? (crc_result_i & `CRC5_MASK)
                                                : crc_result_i;
    if (crc_setup_reg[`CRCS_INV_BIT]) begin
      tx_value_next = crc_setup_reg[`CRCS_WIDTH_BIT] ? (~crc_result_i & `CRC5_MASK)
                                                     : ~crc_result_i;
    end else begin
      tx_value_next = crc_masked;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crc_load_reg <= 1'b0;
      start_reg <= `PRESET_ZERO;
      accumulate_reg <= 1'b0;
      tx_value_reg <= `PRESET_ZERO;
    end else begin
      crc_load_reg <= crc_load_next;
      start_reg <= start_next;
      accumulate_reg <= accumulate_next;
      tx_value_reg <= tx_value_next;
    end
  end

  // ------------------------------------------------------------
  // receive rate
  // ------------------------------------------------------------
  always_comb begin
    rx_rate_next = rate_reg;
    if (!mode_reg[`MODE_READER_BIT]) begin
      rx_rate_next[`RATE_MSB] = 1'b0;
    end
    rx_reserved_next = ~rate_defined(rx_rate_next);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_rate_reg <= `RATE_RESET;
      rx_reserved_reg <= 1'b1;
    end else begin
      rx_rate_reg <= rx_rate_next;
      rx_reserved_reg <= rx_reserved_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign awready_o = awready_reg;
  assign wready_o = wready_reg;
  assign bvalid_o = bvalid_reg;
  assign bresp_o = bresp_reg;
  assign arready_o = arready_reg;
  assign rvalid_o = rvalid_reg;
  assign rdata_o = rdata_reg;
  assign rresp_o = rresp_reg;
  assign crc_enable_o = crc_setup_reg[`CRCS_EN_BIT];
  assign crc_width5_o = crc_setup_reg[`CRCS_WIDTH_BIT];
  assign crc_load_o = crc_load_reg;
  assign crc_start_value_o = start_reg;
  assign crc_accumulate_o = accumulate_reg;
  assign crc_tx_value_o = tx_value_reg;
  assign rx_symbol_rate_o = rx_rate_reg;
  assign rx_rate_reserved_o = rx_reserved_reg;

endmodule

`default_nettype wire

// ### sim/tx_crc_and_rx_rate_config_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_rate_regs.svh"

module tx_crc_and_rx_rate_config_sva (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // register bus
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  // encoder and receive side
  input wire logic frame_start_i,
  input wire logic crc_enable_o,
  input wire logic crc_width5_o,
  input wire logic crc_load_o,
  input wire logic [15:0] crc_start_value_o,
  input wire logic [15:0] crc_tx_value_o,
  input wire logic [2:0] rx_symbol_rate_o,
  input wire logic rx_rate_reserved_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_write_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_read_taken;
    arvalid_i && arready_o;
  endsequence

  a_write_answer: assert property (s_write_taken |=> bvalid_o && !awready_o && !wready_o)
    else $error("write response missing after handshake");
  a_read_answer: assert property (s_read_taken |=> rvalid_o && !arready_o)
    else $error("read response missing after handshake");
  a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped before bready");
  a_rdata_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped before rready");
  a_ready_return: assert property (bvalid_o && bready_i |=> !bvalid_o && awready_o && wready_o)
    else $error("write channel not free after response");
  a_load_start: assert property (frame_start_i && crc_enable_o |=> crc_load_o)
    else $error("no crc load after frame start");
  a_load_cause: assert property (crc_load_o |-> $past(frame_start_i) && $past(crc_enable_o))
    else $error("crc load without enabled frame start");
  a_crc5_start: assert property (crc_load_o && $past(crc_width5_o) |-> crc_start_value_o[15:8] == 8'h00)
    else $error("5-bit start value has high byte set");
  a_crc5_tx: assert property (crc_width5_o && $past(crc_width5_o) |-> crc_tx_value_o[15:5] == 11'h000)
    else $error("5-bit crc value wider than 5 bits");
  a_rate_flag: assert property (rx_rate_reserved_o == !(rx_symbol_rate_o inside {`RATE_106, `RATE_424, `RATE_848}))
    else $error("reserved rate flag disagrees with rate");
endmodule

bind tx_crc_and_rx_rate_config tx_crc_and_rx_rate_config_sva chk (.*);

`default_nettype wire

// ### sim/tx_crc_and_rx_rate_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_rate_regs.svh"

module tx_crc_and_rx_rate_config_bench;
  import crc_rate_pkg::*;
  localparam logic [7:0] CRC_A = {`CRC_SETUP_IDX, 2'b00};
  localparam logic [7:0] RATE_A = {`RATE_SETUP_IDX, 2'b00};
  localparam logic [7:0] MODE_A = {`MODE_SETUP_IDX, 2'b00};
  logic ref_clk_i, resetn_i = 1'b0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [2:0] awprot_i = 3'h0, arprot_i = 3'h0;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [3:0] wstrb_i = 4'h0;
  logic frame_start_i = 1'b0, byte_done_i = 1'b0, det_valid_i = 1'b0, det_is_424_i = 1'b0;
  logic [15:0] crc_result_i = 16'h0000;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic crc_enable_o, crc_width5_o, crc_load_o, crc_accumulate_o, rx_rate_reserved_o;
  logic [15:0] crc_start_value_o, crc_tx_value_o;
  logic [2:0] rx_symbol_rate_o;
  int n_errors = 0;
  int samples_checked = 0;
  logic [15:0] presets [8] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff, 16'h0012, 16'he012,
                               16'h0000, 16'hbeef};
  logic [31:0] tx_cfg [4] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0007, 32'h0000_0005};
  logic [15:0] tx_exp [4] = '{16'h1234, 16'hedcb, 16'h000b, 16'h0014};
  logic [2:0] codes [4] = '{3'h4, 3'h6, 3'h7, 3'h5};

  tx_crc_and_rx_rate_config DUT (.*);

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------------------
  // bus and event tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // response ready held back one cycle so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge ref_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= s;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b0;
    do begin
      @(posedge ref_clk_i);
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
    end while ((awvalid_i && awready_o !== 1'b1) || (wvalid_i && wready_o !== 1'b1));
    @(posedge ref_clk_i);
    bready_i <= 1'b1;
    do @(posedge ref_clk_i); while (bvalid_o !== 1'b1);
    chk(32'(bresp_o), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge ref_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b0;
    do @(posedge ref_clk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    @(posedge ref_clk_i);
    rready_i <= 1'b1;
    do @(posedge ref_clk_i); while (rvalid_o !== 1'b1);
    chk(rdata_o, exp);
    chk(32'(rresp_o), 32'(er));
  endtask

  task automatic evt(input logic fs, input logic bd, input logic dv, input logic d4);
    @(posedge ref_clk_i);
    frame_start_i <= fs;
    byte_done_i <= bd;
    det_valid_i <= dv;
    det_is_424_i <= d4;
    @(posedge ref_clk_i);
    frame_start_i <= 1'b0;
    byte_done_i <= 1'b0;
    det_valid_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    crc_result_i <= 16'h1234;
    rd(CRC_A, 32'h0000_0000, `RESP_OKAY);
    rd(RATE_A, 32'h0000_0000, `RESP_OKAY);
    chk(32'(crc_enable_o), 32'h0000_0000);
    wr(CRC_A, 32'hffff_ffff, 4'hf, `RESP_OKAY);
    rd(CRC_A, 32'hffff_007f, `RESP_OKAY);
    wr(CRC_A, 32'h1234_0000, 4'hc, `RESP_OKAY);
    rd(CRC_A, 32'h1234_007f, `RESP_OKAY);
    for (int w = 0; w < 2; w++) begin
      for (int s = 0; s < 8; s++) begin
        wr(CRC_A, {16'hbeef, 9'h000, 1'b0, 3'(s), w[0], 2'b01}, 4'hf, `RESP_OKAY);
        evt(1'b1, 1'b0, 1'b0, 1'b0);
        chk(32'(crc_load_o), 32'h0000_0001);
        chk(32'(crc_start_value_o), 32'(w ? presets[s] & 16'h00ff : presets[s]));
      end
    end
    wr(CRC_A, 32'h0000_0041, 4'hf, `RESP_OKAY);
    evt(1'b1, 1'b0, 1'b0, 1'b0);
    chk(32'(crc_accumulate_o), 32'h0000_0000);
    evt(1'b0, 1'b1, 1'b0, 1'b0);
    chk(32'(crc_accumulate_o), 32'h0000_0001);
    wr(CRC_A, 32'h0000_0001, 4'hf, `RESP_OKAY);
    evt(1'b1, 1'b0, 1'b0, 1'b0);
    chk(32'(crc_accumulate_o), 32'h0000_0001);
    wr(CRC_A, 32'h0000_0040, 4'hf, `RESP_OKAY);
    evt(1'b1, 1'b0, 1'b0, 1'b0);
    chk(32'(crc_load_o), 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(CRC_A, tx_cfg[i], 4'hf, `RESP_OKAY);
      @(negedge ref_clk_i);
      chk(32'(crc_tx_value_o), 32'(tx_exp[i]));
    end
    wr(MODE_A, 32'h0000_0002, 4'hf, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(RATE_A, 32'(codes[i]), 4'hf, `RESP_OKAY);
      @(negedge ref_clk_i);
      chk(32'(rx_symbol_rate_o), 32'(codes[i]));
      chk(32'(rx_rate_reserved_o), 32'(codes[i] == 3'h5));
    end
    wr(RATE_A, 32'hffff_ffff, 4'hf, `RESP_OKAY);
    rd(RATE_A, 32'h0000_0007, `RESP_OKAY);
    wr(MODE_A, 32'h0000_0000, 4'hf, `RESP_OKAY);
    @(negedge ref_clk_i);
    chk(32'(rx_symbol_rate_o), 32'h0000_0003);
    // detector runs only with auto detection on
    wr(MODE_A, 32'h0000_0003, 4'hf, `RESP_OKAY);
    evt(1'b0, 1'b0, 1'b1, 1'b1);
    rd(RATE_A, 32'h0000_0006, `RESP_OKAY);
    evt(1'b0, 1'b0, 1'b1, 1'b0);
    rd(RATE_A, 32'h0000_0004, `RESP_OKAY);
    wr(MODE_A, 32'h0000_0002, 4'hf, `RESP_OKAY);
    evt(1'b0, 1'b0, 1'b1, 1'b1);
    rd(RATE_A, 32'h0000_0004, `RESP_OKAY);
    wr(8'h04, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    rd(8'h04, 32'h0000_0000, `RESP_SLVERR);
    rd(MODE_A, 32'h0000_0002, `RESP_OKAY);
    report_and_stop();
  end

  initial begin
    repeat (4000) @(posedge ref_clk_i);
    n_errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire
